// File: rtl/hpq_classifier.sv
module hpq_classifier (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   hpq_cfg_if.cls           cfg,
   input  wire logic        ing_valid,
   input  wire logic        ing_bcast,
   input  wire logic        ing_dscp_hit,
   input  wire logic [1:0]  ing_dscp_prio,
   input  wire logic        ing_tagged,
   input  wire logic [1:0]  ing_tag_prio,
   input  wire logic        egr_valid,
   input  wire logic        egr_rx_tagged,
   output logic             cls_valid_r,
   output logic [1:0]       cls_prio_r,
   output logic [1:0]       cls_queue_r,
   output logic             storm_meter_r,
   output logic             egr_valid_r,
   output logic             egr_insert_r,
   output logic             egr_strip_r,
   output logic [11:0]      egr_vid_r
);

   logic        cls_valid_nxt;
   logic [1:0]  cls_prio_nxt;
   logic [1:0]  cls_queue_nxt;
   logic        storm_meter_nxt;
   logic        egr_valid_nxt;
   logic        egr_insert_nxt;
   logic        egr_strip_nxt;
   logic [11:0] egr_vid_nxt;
   logic        p1p_hit;
   logic        dscp_hit;

   // ==========================================================
   // Ingress priority and queue choice
   // ==========================================================
   always_comb begin
      p1p_hit         = cfg.p1p_en & ing_tagged;
      dscp_hit        = cfg.dscp_en & ing_dscp_hit;
      cls_valid_nxt   = ing_valid;
      storm_meter_nxt = ing_valid & ing_bcast & cfg.storm_en;
      if (p1p_hit | dscp_hit) begin
         // Both classifiers may fire; their results are merged bitwise
         cls_prio_nxt = (p1p_hit ? ing_tag_prio : 2'h0)
                      | (dscp_hit ? ing_dscp_prio : 2'h0);
      end else begin
         cls_prio_nxt = cfg.port_prio;
      end
      // Single queue mode ignores the class; it still goes out for statistics
      cls_queue_nxt = cfg.multi_q ? cls_prio_nxt : 2'h0;
   end

   // ==========================================================
   // Egress tag handling
   // ==========================================================
   always_comb begin
      egr_valid_nxt  = egr_valid;
      egr_insert_nxt = egr_valid & cfg.tag_ins & ~egr_rx_tagged;
      egr_strip_nxt  = egr_valid & cfg.tag_rm & egr_rx_tagged;
      egr_vid_nxt    = cfg.vid;
   end

   // Registered results, one cycle after the request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cls_valid_r   <= 1'b0;
         cls_prio_r    <= 2'h0;
         cls_queue_r   <= 2'h0;
         storm_meter_r <= 1'b0;
         egr_valid_r   <= 1'b0;
         egr_insert_r  <= 1'b0;
         egr_strip_r   <= 1'b0;
         egr_vid_r     <= 12'h000;
      end else begin
         cls_valid_r   <= cls_valid_nxt;
         cls_prio_r    <= cls_prio_nxt;
         cls_queue_r   <= cls_queue_nxt;
         storm_meter_r <= storm_meter_nxt;
         egr_valid_r   <= egr_valid_nxt;
         egr_insert_r  <= egr_insert_nxt;
         egr_strip_r   <= egr_strip_nxt;
         egr_vid_r     <= egr_vid_nxt;
      end
   end

endmodule

// File: rtl/hpq_top.sv
// Functional notes
// - Control bit 7 enables broadcast storm protection for ingress packets.
// - Control bit 6 enables DiffServ code point priority classification.
// - Control bit 5 enables 802.1p tag priority classification.
// - Bits 4-3 give the default priority 0..3 when classifiers are off or miss.
// - With both classifiers on and either one hitting, OR of the hit priorities replaces the port default.
// - Bit 2 adds a tag carrying the default VID to untagged egress packets.
// - Tag insertion never adds a second tag to already tagged packets.
// - Bit 1 strips the tag on egress from packets received tagged.
// - Tag removal leaves packets received untagged unmodified.
// - Bit 0 splits the output queue into four priority queues.
// - Bit 0 clear uses one output queue with no priority differentiation.
// - Reserved range reads zero, ignores writes; control bits 15-8 read zero.
// - Inserted tag VID comes from VID control low 12 bits, reset 0x001.
//
// Implementation choice: the AXI4-Lite interface to the registers.

`include "hpq_regs.svh"

module hpq_top #(
   parameter int ADDR_W = 16
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Ingress packet descriptor from the switch core
   input  wire logic              ing_valid,
   input  wire logic              ing_bcast,
   input  wire logic              ing_dscp_hit,
   input  wire logic [1:0]        ing_dscp_prio,
   input  wire logic              ing_tagged,
   input  wire logic [1:0]        ing_tag_prio,
   // Egress packet descriptor from the switch core
   input  wire logic              egr_valid,
   input  wire logic              egr_rx_tagged,
   // Decisions back to the switch core
   output logic                   cls_valid,
   output logic [1:0]             cls_prio,
   output logic [1:0]             cls_queue,
   output logic                   storm_meter,
   output logic                   egr_dec_valid,
   output logic                   egr_insert,
   output logic                   egr_strip,
   output logic [11:0]            egr_vid,
   // Configuration levels seen by the queue manager
   output logic                   storm_protect_en,
   output logic                   multi_queue_en
);

   // ==========================================================
   // Address decode
   // ==========================================================
   // Shared by both channels so reads and writes agree on the map
   function automatic hpq_pkg::hpq_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] a;
      a = addr;
      if (a == ADDR_W'({`HPQ_IDX_CTRL1, 2'b00}))
         decode = hpq_pkg::hpq_sel_ctrl1;
      else if (a == ADDR_W'({`HPQ_IDX_VIDCR, 2'b00}))
         decode = hpq_pkg::hpq_sel_vidcr;
      else if (a == ADDR_W'({`HPQ_IDX_RSV_LO, 2'b00}) || a == ADDR_W'({`HPQ_IDX_RSV_MID, 2'b00})
               || a == ADDR_W'({`HPQ_IDX_RSV_HI, 2'b00}))
         decode = hpq_pkg::hpq_sel_rsv;
      else
         decode = hpq_pkg::hpq_sel_none;
   endfunction

   // Byte-lane merge of a 16-bit register, read-only bits kept
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [15:0] wmask);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      merge = (old & ~lanes) | (data[15:0] & lanes);
   endfunction

   // ==========================================================
   // Registers and channel state
   // ==========================================================
   hpq_pkg::hpq_wr_state_t wr_state_r, wr_state_nxt;
   hpq_pkg::hpq_rd_state_t rd_state_r, rd_state_nxt;
   logic                   aw_got_r, aw_got_nxt;
   logic                   w_got_r, w_got_nxt;
   logic [ADDR_W-1:0]      awaddr_r, awaddr_nxt;
   logic [31:0]            wdata_r, wdata_nxt;
   logic [3:0]             wstrb_r, wstrb_nxt;
   logic                   awready_r, awready_nxt;
   logic                   wready_r, wready_nxt;
   logic                   bvalid_r, bvalid_nxt;
   logic [1:0]             bresp_r, bresp_nxt;
   logic                   arready_r, arready_nxt;
   logic                   rvalid_r, rvalid_nxt;
   logic [1:0]             rresp_r, rresp_nxt;
   logic [31:0]            rdata_r, rdata_nxt;
   logic [15:0]            ctrl1_r, ctrl1_nxt;
   logic [15:0]            vidcr_r, vidcr_nxt;
   logic                   aw_hs, w_hs, ar_hs;
   logic [ADDR_W-1:0]      wr_addr;
   logic [31:0]            wr_data;
   logic [3:0]             wr_strb;
   hpq_pkg::hpq_sel_t      wr_sel, rd_sel;

   // ==========================================================
   // Write channel
   // ==========================================================
   // Address and data are taken in either order; the write lands once both are held
   always_comb begin
      aw_hs        = s_axi_awvalid & awready_r;
      w_hs         = s_axi_wvalid & wready_r;
      wr_addr      = aw_hs ? s_axi_awaddr : awaddr_r;
      wr_data      = w_hs ? s_axi_wdata : wdata_r;
      wr_strb      = w_hs ? s_axi_wstrb : wstrb_r;
      wr_sel       = decode(wr_addr);
      wr_state_nxt = wr_state_r;
      aw_got_nxt   = aw_got_r | aw_hs;
      w_got_nxt    = w_got_r | w_hs;
      awaddr_nxt   = wr_addr;
      wdata_nxt    = wr_data;
      wstrb_nxt    = wr_strb;
      bvalid_nxt   = bvalid_r;
      bresp_nxt    = bresp_r;
      ctrl1_nxt    = ctrl1_r;
      vidcr_nxt    = vidcr_r;
      unique case (wr_state_r)
         hpq_pkg::hpq_w_idle: begin
            if (aw_got_nxt && w_got_nxt) begin
               wr_state_nxt = hpq_pkg::hpq_w_resp;
               bvalid_nxt   = 1'b1;
               bresp_nxt    = `HPQ_RESP_OKAY;
               aw_got_nxt   = 1'b0;
               w_got_nxt    = 1'b0;
               unique case (wr_sel)
                  hpq_pkg::hpq_sel_ctrl1: ctrl1_nxt = merge(ctrl1_r, wr_data, wr_strb,
                                                            `HPQ_CTRL1_WMASK);
                  hpq_pkg::hpq_sel_vidcr: vidcr_nxt = merge(vidcr_r, wr_data, wr_strb,
                                                            `HPQ_VIDCR_WMASK);
                  hpq_pkg::hpq_sel_rsv:   ;
                  hpq_pkg::hpq_sel_none:  bresp_nxt = `HPQ_RESP_SLVERR;
               endcase
            end
         end
         hpq_pkg::hpq_w_resp: begin
            if (s_axi_bready) begin
               wr_state_nxt = hpq_pkg::hpq_w_idle;
               bvalid_nxt   = 1'b0;
            end
         end
      endcase
      // Readies are registered, so they drop the cycle after the beat is taken
      awready_nxt = (wr_state_nxt == hpq_pkg::hpq_w_idle) & ~aw_got_nxt;
      wready_nxt  = (wr_state_nxt == hpq_pkg::hpq_w_idle) & ~w_got_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_r <= hpq_pkg::hpq_w_idle;
         aw_got_r   <= 1'b0;
         w_got_r    <= 1'b0;
         awaddr_r   <= '0;
         wdata_r    <= 32'h0000_0000;
         wstrb_r    <= 4'h0;
         awready_r  <= 1'b0;
         wready_r   <= 1'b0;
         bvalid_r   <= 1'b0;
         bresp_r    <= `HPQ_RESP_OKAY;
         ctrl1_r    <= `HPQ_CTRL1_RST;
         vidcr_r    <= `HPQ_VIDCR_RST;
      end else begin
         wr_state_r <= wr_state_nxt;
         aw_got_r   <= aw_got_nxt;
         w_got_r    <= w_got_nxt;
         awaddr_r   <= awaddr_nxt;
         wdata_r    <= wdata_nxt;
         wstrb_r    <= wstrb_nxt;
         awready_r  <= awready_nxt;
         wready_r   <= wready_nxt;
         bvalid_r   <= bvalid_nxt;
         bresp_r    <= bresp_nxt;
         ctrl1_r    <= ctrl1_nxt;
         vidcr_r    <= vidcr_nxt;
      end
   end

   // ==========================================================
   // Read channel
   // ==========================================================
   // Read data is captured at the address beat and held until taken
   always_comb begin
      ar_hs        = s_axi_arvalid & arready_r;
      rd_sel       = decode(s_axi_araddr);
      rd_state_nxt = rd_state_r;
      rvalid_nxt   = rvalid_r;
      rresp_nxt    = rresp_r;
      rdata_nxt    = rdata_r;
      unique case (rd_state_r)
         hpq_pkg::hpq_r_idle: begin
            if (ar_hs) begin
               rd_state_nxt = hpq_pkg::hpq_r_resp;
               rvalid_nxt   = 1'b1;
               rresp_nxt    = `HPQ_RESP_OKAY;
               unique case (rd_sel)
                  hpq_pkg::hpq_sel_ctrl1: rdata_nxt = {16'h0000, ctrl1_r & `HPQ_CTRL1_WMASK};
                  hpq_pkg::hpq_sel_vidcr: rdata_nxt = {16'h0000, vidcr_r};
                  hpq_pkg::hpq_sel_rsv:   rdata_nxt = {16'h0000, `HPQ_RSV_VALUE};
                  hpq_pkg::hpq_sel_none: begin
                     rdata_nxt = 32'h0000_0000;
                     rresp_nxt = `HPQ_RESP_SLVERR;
                  end
               endcase
            end
         end
         hpq_pkg::hpq_r_resp: begin
            if (s_axi_rready) begin
               rd_state_nxt = hpq_pkg::hpq_r_idle;
               rvalid_nxt   = 1'b0;
            end
         end
      endcase
      arready_nxt = (rd_state_nxt == hpq_pkg::hpq_r_idle);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r <= hpq_pkg::hpq_r_idle;
         arready_r  <= 1'b0;
         rvalid_r   <= 1'b0;
         rresp_r    <= `HPQ_RESP_OKAY;
         rdata_r    <= 32'h0000_0000;
      end else begin
         rd_state_r <= rd_state_nxt;
         arready_r  <= arready_nxt;
         rvalid_r   <= rvalid_nxt;
         rresp_r    <= rresp_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   // ==========================================================
   // Configuration towards the classifier
   // ==========================================================
   hpq_cfg_if cfg_bus ();

   // Fields fan out straight from the register flops
   assign cfg_bus.storm_en  = ctrl1_r[`HPQ_BIT_STORM];
   assign cfg_bus.dscp_en   = ctrl1_r[`HPQ_BIT_DSCP];
   assign cfg_bus.p1p_en    = ctrl1_r[`HPQ_BIT_P1P];
   assign cfg_bus.port_prio = ctrl1_r[`HPQ_PRIO_MSB:`HPQ_PRIO_LSB];
   assign cfg_bus.tag_ins   = ctrl1_r[`HPQ_BIT_TAG_INS];
   assign cfg_bus.tag_rm    = ctrl1_r[`HPQ_BIT_TAG_RM];
   assign cfg_bus.multi_q   = ctrl1_r[`HPQ_BIT_MULTI_Q];
   assign cfg_bus.vid       = vidcr_r[`HPQ_VID_MSB:`HPQ_VID_LSB];

   // Descriptors come from switch core logic on aclk, so no synchronisers
   hpq_classifier u_cls (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .cfg           (cfg_bus),
      .ing_valid     (ing_valid),
      .ing_bcast     (ing_bcast),
      .ing_dscp_hit  (ing_dscp_hit),
      .ing_dscp_prio (ing_dscp_prio),
      .ing_tagged    (ing_tagged),
      .ing_tag_prio  (ing_tag_prio),
      .egr_valid     (egr_valid),
      .egr_rx_tagged (egr_rx_tagged),
      .cls_valid_r   (cls_valid),
      .cls_prio_r    (cls_prio),
      .cls_queue_r   (cls_queue),
      .storm_meter_r (storm_meter),
      .egr_valid_r   (egr_dec_valid),
      .egr_insert_r  (egr_insert),
      .egr_strip_r   (egr_strip),
      .egr_vid_r     (egr_vid)
   );

   // ==========================================================
   // Outputs
   // ==========================================================
   assign s_axi_awready    = awready_r;
   assign s_axi_wready     = wready_r;
   assign s_axi_bvalid     = bvalid_r;
   assign s_axi_bresp      = bresp_r;
   assign s_axi_arready    = arready_r;
   assign s_axi_rvalid     = rvalid_r;
   assign s_axi_rresp      = rresp_r;
   assign s_axi_rdata      = rdata_r;
   assign storm_protect_en = ctrl1_r[`HPQ_BIT_STORM];
   assign multi_queue_en   = ctrl1_r[`HPQ_BIT_MULTI_Q];

endmodule

// File: shared/hpq_cfg_if.sv
// ==========================================================
// Configuration carried from the register bank to the classifier
// ==========================================================
interface hpq_cfg_if;
   logic        storm_en;
   logic        dscp_en;
   logic        p1p_en;
   logic [1:0]  port_prio;
   logic        tag_ins;
   logic        tag_rm;
   logic        multi_q;
   logic [11:0] vid;

   modport regs (output storm_en, output dscp_en, output p1p_en, output port_prio,
                 output tag_ins, output tag_rm, output multi_q, output vid);
   modport cls  (input storm_en, input dscp_en, input p1p_en, input port_prio,
                 input tag_ins, input tag_rm, input multi_q, input vid);
endinterface

// File: shared/hpq_pkg.sv
package hpq_pkg;

   // ==========================================================
   // Bus channel states, one-hot
   // ==========================================================
   typedef enum logic [1:0] {
      hpq_w_idle = 2'b01,
      hpq_w_resp = 2'b10
   } hpq_wr_state_t;

   typedef enum logic [1:0] {
      hpq_r_idle = 2'b01,
      hpq_r_resp = 2'b10
   } hpq_rd_state_t;

   // Register selected by an address
   typedef enum logic [2:0] {
      hpq_sel_none,
      hpq_sel_rsv,
      hpq_sel_ctrl1,
      hpq_sel_vidcr
   } hpq_sel_t;

endpackage

// File: shared/hpq_regs.svh
`ifndef HPQ_REGS_SVH
`define HPQ_REGS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define HPQ_IDX_RSV_LO      12'h536
`define HPQ_IDX_RSV_MID     12'h538
`define HPQ_IDX_RSV_HI      12'h53a
`define HPQ_IDX_CTRL1       12'h540
`define HPQ_IDX_VIDCR       12'h544

// ==========================================================
// Field positions of host_port_control_one
// ==========================================================
`define HPQ_BIT_STORM       7
`define HPQ_BIT_DSCP        6
`define HPQ_BIT_P1P         5
`define HPQ_PRIO_MSB        4
`define HPQ_PRIO_LSB        3
`define HPQ_BIT_TAG_INS     2
`define HPQ_BIT_TAG_RM      1
`define HPQ_BIT_MULTI_Q     0

// ==========================================================
// Field positions of host_port_vid_control
// ==========================================================
`define HPQ_VID_MSB         11
`define HPQ_VID_LSB         0

// ==========================================================
// Reset values and writable masks
// ==========================================================
`define HPQ_CTRL1_RST       16'h0000
`define HPQ_CTRL1_WMASK     16'h00ff
`define HPQ_VIDCR_RST       16'h0001
`define HPQ_VIDCR_WMASK     16'hffff
`define HPQ_RSV_VALUE       16'h0000

// ==========================================================
// Bus responses
// ==========================================================
`define HPQ_RESP_OKAY       2'b00
`define HPQ_RESP_SLVERR     2'b10

`endif

// File: testbench/hpq_top_asserts.sv
// ==========================================================
// Port-level checker for the host port QoS block
// ==========================================================
module hpq_top_asserts (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        ing_valid,
   input wire logic        ing_bcast,
   input wire logic        egr_valid,
   input wire logic        egr_rx_tagged,
   input wire logic        cls_valid,
   input wire logic [1:0]  cls_prio,
   input wire logic [1:0]  cls_queue,
   input wire logic        storm_meter,
   input wire logic        egr_dec_valid,
   input wire logic        egr_insert,
   input wire logic        egr_strip,
   input wire logic        storm_protect_en,
   input wire logic        multi_queue_en
);
   timeunit 1ns;
   timeprecision 1ns;

   // All checks share one clock; reset cancels attempts in flight
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_storm_pulse: assert property (1 |=> storm_meter == $past(ing_valid && ing_bcast && storm_protect_en))
      else $error("storm pulse wrong");
   a_desc_latency: assert property (1 |=> cls_valid == $past(ing_valid) && egr_dec_valid == $past(egr_valid))
      else $error("decision latency wrong");
   a_multi_queue: assert property (cls_valid && $past(multi_queue_en) |-> cls_queue == cls_prio)
      else $error("queue differs from priority");
   a_single_queue: assert property (cls_valid && !$past(multi_queue_en) |-> cls_queue == 2'h0)
      else $error("single queue not used");
   a_no_double_tag: assert property (egr_insert |-> $past(egr_valid && !egr_rx_tagged))
      else $error("tag added to tagged packet");
   a_untagged_kept: assert property (egr_strip |-> $past(egr_valid && egr_rx_tagged))
      else $error("untagged packet modified");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   // Response must stand while the master stalls, or data is lost
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");

   c_storm: cover property (storm_meter);
   c_high_q: cover property (cls_valid && cls_queue == 2'h3);
   c_insert: cover property (egr_insert);
   c_strip: cover property (egr_strip);
endmodule

bind hpq_top hpq_top_asserts u_asserts (.*);

// File: testbench/tb.sv
`include "hpq_regs.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // Addresses and responses
   // ==========================================================
   localparam logic [15:0] A_CTL = {2'h0, `HPQ_IDX_CTRL1, 2'h0};
   localparam logic [15:0] A_VID = {2'h0, `HPQ_IDX_VIDCR, 2'h0};
   localparam logic [15:0] A_RSV = {2'h0, `HPQ_IDX_RSV_LO, 2'h0};
   localparam logic [1:0]  OK    = `HPQ_RESP_OKAY;
   localparam logic [1:0]  ER    = `HPQ_RESP_SLVERR;

   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, cls_prio, cls_queue;
   logic [1:0]  ing_dscp_prio = 2'h0, ing_tag_prio = 2'h0;
   logic        ing_valid = 1'b0, ing_bcast = 1'b0, ing_dscp_hit = 1'b0, ing_tagged = 1'b0;
   logic        egr_valid = 1'b0, egr_rx_tagged = 1'b0;
   logic        cls_valid, storm_meter, egr_dec_valid, egr_insert, egr_strip;
   logic        storm_protect_en, multi_queue_en;
   logic [11:0] egr_vid;
   int          mismatches = 0, cmp_count = 0;

   hpq_top dut (.*);

   always #50 aclk = ~aclk;

   // ==========================================================
   // Reporting
   // ==========================================================
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // A bounded wait that ran out ends the run at once
   task automatic hang(input int n);
      if (n >= 40) begin
         mismatches++;
         close_out();
      end
   endtask

   // ==========================================================
   // Bus cycles; ready is raised only after the answer, so
   // every transfer also exercises a stalled response
   // ==========================================================
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         s_axi_bready <= s_axi_bvalid;
      end
      hang(n);
      chk("bresp", 32'(er), 32'(s_axi_bresp));
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         s_axi_rready <= s_axi_rvalid;
      end
      hang(n);
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Program the control byte, then send one ingress descriptor
   task automatic cls(input logic [7:0] c, input logic [6:0] p, input logic [4:0] e);
      wr(A_CTL, 32'(c), 4'h1, OK);
      rd(A_CTL, 32'(c), OK);
      chk("enables", 32'({c[7], c[0]}), 32'({storm_protect_en, multi_queue_en}));
      {ing_bcast, ing_dscp_hit, ing_dscp_prio, ing_tagged, ing_tag_prio} <= p;
      ing_valid <= 1'b1;
      @(posedge aclk);
      ing_valid <= 1'b0;
      @(posedge aclk);
      chk("class", 32'({1'b1, e}), 32'({cls_valid, cls_prio, cls_queue, storm_meter}));
   endtask

   task automatic eg(input logic rx, input logic [1:0] e);
      egr_rx_tagged <= rx;
      egr_valid <= 1'b1;
      @(posedge aclk);
      egr_valid <= 1'b0;
      @(posedge aclk);
      chk("egress", 32'({1'b1, e}), 32'({egr_dec_valid, egr_insert, egr_strip}));
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      int i;
      logic [1:0] m;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("vid", 32'h1, 32'(egr_vid));
      rd(A_CTL, 32'h0, OK);
      rd(A_VID, 32'h1, OK);
      for (i = 0; i < 3; i++) begin
         wr(A_RSV + 16'(i * 8), 32'hffff, 4'h3, OK);
         rd(A_RSV + 16'(i * 8), 32'h0, OK);
      end
      wr(A_CTL, 32'hffff_ffff, 4'hf, OK);
      rd(A_CTL, 32'h00ff, OK);
      wr(A_CTL, 32'h0, 4'h2, OK);
      rd(A_CTL, 32'h00ff, OK);
      wr(A_CTL + 16'h4, 32'h1234, 4'h3, ER);
      rd(A_CTL + 16'h4, 32'h0, ER);
      // Packet fields: bcast, dscp hit, dscp prio, tagged, tag prio
      cls(8'h11, 7'h2f, 5'h14);
      cls(8'h19, 7'h00, 5'h1e);
      cls(8'h61, 7'h35, 5'h1e);
      cls(8'h51, 7'h1f, 5'h14);
      cls(8'h51, 7'h2e, 5'h0a);
      cls(8'h29, 7'h2e, 5'h14);
      cls(8'h29, 7'h38, 5'h0a);
      cls(8'h98, 7'h40, 5'h19);
      cls(8'h18, 7'h40, 5'h18);
      cls(8'h60, 7'h0f, 5'h18);
      // Every insert and strip combination, both packet kinds
      for (i = 0; i < 4; i++) begin
         m = 2'(i);
         wr(A_CTL, 32'({m, 1'b0}), 4'h1, OK);
         eg(1'b0, {m[1], 1'b0});
         eg(1'b1, {1'b0, m[0]});
      end
      wr(A_VID, 32'h0abc, 4'h3, OK);
      rd(A_VID, 32'h0abc, OK);
      chk("vid", 32'habc, 32'(egr_vid));
      // Second reset in mid-run must restore the defaults
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_VID, 32'h1, OK);
      rd(A_CTL, 32'h0, OK);
      close_out();
   end
endmodule
